// ### hw/csec_bit_sync.sv
// Two-stage level synchroniser
`timescale 1ns/100ps
`default_nettype none
module csec_bit_sync (
	// Destination clock
	input  wire logic i_clk,
	// Level in and out
	input  wire logic i_d,
	output logic      o_q
);
	//=====================================================================
	// State: first stage feeds only the second
	typedef struct packed {
		logic s1;
		logic s2;
	} csec_bs_type;
	csec_bs_type bs_reg;  // Stages
	csec_bs_type bs_next; // Next stages

	// Shift the level through
	always_comb begin
		bs_next    = bs_reg;
		bs_next.s1 = i_d;
		bs_next.s2 = bs_reg.s1;
	end

	// No reset: this also carries a reset level
	always_ff @(posedge i_clk) begin
		bs_reg <= bs_next;
	end

	assign o_q = bs_reg.s2;
endmodule
`default_nettype wire

// ### hw/csec_hs_xfer.sv
// Toggle handshake carrying one word between two clocks
`timescale 1ns/100ps
`default_nettype none
module csec_hs_xfer #(
	parameter int W = 8
) (
	// Source side
	input  wire logic         i_src_clk,
	input  wire logic         i_src_rstn,
	input  wire logic         i_src_load,
	input  wire logic [W-1:0] i_src_data,
	output logic              o_src_ready,
	// Destination side
	input  wire logic         i_dst_clk,
	input  wire logic         i_dst_rstn,
	output logic [W-1:0]      o_dst_data,
	output logic              o_dst_valid
);
	//=====================================================================
	// Per-domain state; each struct is written in its own domain only
	typedef struct packed {
		logic         req;
		logic         ack_m; // First stage, read only by ack_s
		logic         ack_s;
		logic [W-1:0] data;
	} csec_hs_src_type;
	typedef struct packed {
		logic         req_m; // First stage, read only by req_s
		logic         req_s;
		logic         seen;
		logic [W-1:0] data;
		logic         valid;
	} csec_hs_dst_type;
	csec_hs_src_type src_reg;  // Source state
	csec_hs_src_type src_next; // Next source state
	csec_hs_dst_type dst_reg;  // Destination state
	csec_hs_dst_type dst_next; // Next destination state

	// Source: hold the word, flip the request
	always_comb begin
		src_next       = src_reg;
		src_next.ack_m = dst_reg.seen;
		src_next.ack_s = src_reg.ack_m;
		if (i_src_load && (src_reg.req == src_reg.ack_s)) begin
			src_next.req  = ~src_reg.req;
			src_next.data = i_src_data;
		end
	end

	always_ff @(posedge i_src_clk) begin
		if (!i_src_rstn) begin
			src_reg <= '0;
		end else begin
			src_reg <= src_next;
		end
	end

	// Destination: word is stable once the request has crossed
	always_comb begin
		dst_next       = dst_reg;
		dst_next.req_m = src_reg.req;
		dst_next.req_s = dst_reg.req_m;
		dst_next.valid = 1'b0;
		if (dst_reg.req_s != dst_reg.seen) begin
			dst_next.seen  = dst_reg.req_s;
			dst_next.data  = src_reg.data;
			dst_next.valid = 1'b1;
		end
	end

	always_ff @(posedge i_dst_clk) begin
		if (!i_dst_rstn) begin
			dst_reg <= '0;
		end else begin
			dst_reg <= dst_next;
		end
	end

	assign o_src_ready = (src_reg.req == src_reg.ack_s);
	assign o_dst_data  = dst_reg.data;
	assign o_dst_valid = dst_reg.valid;
endmodule
`default_nettype wire

// ### hw/csec_pkg.sv
// Constants and carrier types of the codec slot enable control block
//=====================================================================
// Functional notes
// - Receive serial input only in enabled slots
// - Disabled receive slot: input data is discarded
// - Enabled transmit slot shifts transmit word out
// - Disabled transmit slot: output tri-state or low
//=====================================================================
`default_nettype none
package csec_pkg;
	//=====================================================================
	// Widths
	localparam int CSEC_AW        = 4;  // Register address width
	localparam int CSEC_DW        = 16; // Register and slot word width
	localparam int CSEC_NSLOT     = 16; // Slots per frame
	localparam int CSEC_SLOT_W    = 4;  // Slot counter width
	localparam int CSEC_BCNT_W    = 5;  // Bit-in-slot counter width
	localparam int CSEC_SLOT_BITS = 16; // Default bits per slot
	//=====================================================================
	// Register offsets
	localparam logic [CSEC_AW-1:0] CSEC_OFS_RXEN   = 4'h0;
	localparam logic [CSEC_AW-1:0] CSEC_OFS_TXEN   = 4'h1;
	localparam logic [CSEC_AW-1:0] CSEC_OFS_CTRL   = 4'h2;
	localparam logic [CSEC_AW-1:0] CSEC_OFS_TXDATA = 4'h3;
	localparam logic [CSEC_AW-1:0] CSEC_OFS_RXDATA = 4'h4;
	localparam logic [CSEC_AW-1:0] CSEC_OFS_STATUS = 4'h5;
	//=====================================================================
	// Field positions and reset values
	localparam int CSEC_CTRL_MODE_BIT = 0; // Idle slot output mode
	localparam int CSEC_STAT_RDY_BIT  = 0; // Received word waiting
	localparam int CSEC_STAT_OVF_BIT  = 1; // Received word overwritten
	localparam int CSEC_STAT_SLOT_LSB = 4; // Slot of last word
	localparam logic [CSEC_DW-1:0] CSEC_RST_WORD = 16'h0000;
	//=====================================================================
	// Configuration sent to the link side
	typedef struct packed {
		logic               mode;  // 1 drive low, 0 tri-state
		logic [CSEC_DW-1:0] tx_en; // Transmit slot enables
		logic [CSEC_DW-1:0] rx_en; // Receive slot enables
		logic [CSEC_DW-1:0] txd;   // Transmit buffer word
	} csec_cfg_type;
	// Received word with its slot
	typedef struct packed {
		logic [CSEC_SLOT_W-1:0] slot;
		logic [CSEC_DW-1:0]     data;
	} csec_rxw_type;
	// System-side state
	typedef struct packed {
		logic [CSEC_DW-1:0]     rx_en;
		logic [CSEC_DW-1:0]     tx_en;
		logic                   mode;
		logic [CSEC_DW-1:0]     txd;
		logic [CSEC_DW-1:0]     rxd;
		logic [CSEC_SLOT_W-1:0] rx_slot;
		logic                   ready;
		logic                   ovf;
		logic [CSEC_DW-1:0]     rdata;
	} csec_sys_type;
	// Link-side state
	typedef struct packed {
		csec_cfg_type           cfg;
		logic                   active;  // A frame sync was seen
		logic [CSEC_SLOT_W-1:0] slot;
		logic [CSEC_BCNT_W-1:0] bitn;
		logic [CSEC_DW-1:0]     rxsh;
		logic [CSEC_DW-1:0]     txsh;
		logic                   rx_on;
		logic                   tx_on;
		logic                   sdo;
		logic                   oe;
		logic                   rx_load;
		csec_rxw_type           rx_word;
	} csec_lnk_type;
endpackage
`default_nettype wire

// ### hw/csec_top.sv
// Slot enable control for a TDM codec serial link
`timescale 1ns/100ps
`default_nettype none
module csec_top #(
	parameter int SLOT_BITS = csec_pkg::CSEC_SLOT_BITS
) (
	// System clock and reset
	input  wire logic                          i_mclk,
	input  wire logic                          i_rstn,
	// Register port
	input  wire logic [csec_pkg::CSEC_AW-1:0]  i_addr,
	input  wire logic [csec_pkg::CSEC_DW-1:0]  i_wdata,
	input  wire logic                          i_wr,
	input  wire logic                          i_rd,
	output logic      [csec_pkg::CSEC_DW-1:0]  o_rdata,
	// Codec link
	input  wire logic                          i_link_clk,
	input  wire logic                          i_link_fsync,
	input  wire logic                          i_codec_serial_in,
	output logic                               o_codec_serial_out,
	output logic                               o_codec_serial_out_oe
);
	import csec_pkg::*;

	//=====================================================================
	// Declarations
	localparam logic [CSEC_BCNT_W-1:0] LAST = CSEC_BCNT_W'(SLOT_BITS - 1); // Last bit of a slot

	csec_sys_type s_reg;      // System-side state
	csec_sys_type s_next;     // Next system-side state
	csec_lnk_type l_reg;      // Link-side state
	csec_lnk_type l_next;     // Next link-side state
	csec_cfg_type cfg_out;    // Configuration from the registers
	csec_cfg_type cfg_in;     // Configuration seen at the link
	logic         cfg_valid;  // Fresh configuration arrived
	csec_rxw_type rxw_in;     // Received word at the system side
	logic         rxw_valid;  // Received word arrived
	logic         rxw_ready;  // Link may hand over a word
	logic         lrst_n;     // Reset in the link domain

	//=====================================================================
	// Helpers
	// Address match, used by the write decode and by the overrun check for a data read
	function automatic logic at(input logic [CSEC_AW-1:0] a, input logic [CSEC_AW-1:0] ofs);
		at = (a == ofs);
	endfunction

	// Status word from the received-word flags
	function automatic logic [CSEC_DW-1:0] status(input csec_sys_type s);
		status = '0;
		status[CSEC_STAT_RDY_BIT] = s.ready;
		status[CSEC_STAT_OVF_BIT] = s.ovf;
		status[CSEC_STAT_SLOT_LSB +: CSEC_SLOT_W] = s.rx_slot;
	endfunction

	//=====================================================================
	// Domain crossings
	// Reset follows the system reset into the link domain
	csec_bit_sync u_lrst (
		.i_clk (i_link_clk),
		.i_d   (i_rstn),
		.o_q   (lrst_n)
	);

	// Configuration is resent whenever the path is free, so a write
	// lands at the link within a few clocks of both domains
	assign cfg_out = '{mode: s_reg.mode, tx_en: s_reg.tx_en, rx_en: s_reg.rx_en, txd: s_reg.txd};

	csec_hs_xfer #(
		.W ($bits(csec_cfg_type))
	) u_cfg (
		.i_src_clk   (i_mclk),
		.i_src_rstn  (i_rstn),
		.i_src_load  (1'b1),
		.i_src_data  (cfg_out),
		.o_src_ready (),
		.i_dst_clk   (i_link_clk),
		.i_dst_rstn  (lrst_n),
		.o_dst_data  (cfg_in),
		.o_dst_valid (cfg_valid)
	);

	// Received words travel back one at a time
	csec_hs_xfer #(
		.W ($bits(csec_rxw_type))
	) u_rxw (
		.i_src_clk   (i_link_clk),
		.i_src_rstn  (lrst_n),
		.i_src_load  (l_reg.rx_load),
		.i_src_data  (l_reg.rx_word),
		.o_src_ready (rxw_ready),
		.i_dst_clk   (i_mclk),
		.i_dst_rstn  (i_rstn),
		.o_dst_data  (rxw_in),
		.o_dst_valid (rxw_valid)
	);

	//=====================================================================
	// Register file
	// Writes, reads with side effects, and arrival of received words
	always_comb begin
		s_next       = s_reg;
		s_next.rdata = '0;
		// Register writes
		if (i_wr) begin
			if (at(i_addr, CSEC_OFS_RXEN)) begin
				s_next.rx_en = i_wdata;
			end
			if (at(i_addr, CSEC_OFS_TXEN)) begin
				s_next.tx_en = i_wdata;
			end
			if (at(i_addr, CSEC_OFS_CTRL)) begin
				s_next.mode = i_wdata[CSEC_CTRL_MODE_BIT];
			end
			if (at(i_addr, CSEC_OFS_TXDATA)) begin
				s_next.txd = i_wdata;
			end
		end
		// Register reads; unmapped addresses give zero
		if (i_rd) begin
			case (i_addr)
				CSEC_OFS_RXEN: begin
					s_next.rdata = s_reg.rx_en;
				end
				CSEC_OFS_TXEN: begin
					s_next.rdata = s_reg.tx_en;
				end
				CSEC_OFS_CTRL: begin
					s_next.rdata[CSEC_CTRL_MODE_BIT] = s_reg.mode;
				end
				CSEC_OFS_TXDATA: begin
					s_next.rdata = s_reg.txd;
				end
				CSEC_OFS_RXDATA: begin
					s_next.rdata = s_reg.rxd;
					s_next.ready = 1'b0;
				end
				CSEC_OFS_STATUS: begin
					s_next.rdata = status(s_reg);
					s_next.ovf   = 1'b0;
				end
				default: begin
					s_next.rdata = '0;
				end
			endcase
		end
		// New word: set beats a clear by read in the same cycle
		if (rxw_valid) begin
			s_next.rxd     = rxw_in.data;
			s_next.rx_slot = rxw_in.slot;
			s_next.ready   = 1'b1;
			// Unread word replaced, unless it is being read right now
			if (s_reg.ready && !(i_rd && at(i_addr, CSEC_OFS_RXDATA))) begin
				s_next.ovf = 1'b1;
			end
		end
	end

	// All slot enables start cleared
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			s_reg       <= '0;
			s_reg.rx_en <= CSEC_RST_WORD;
			s_reg.tx_en <= CSEC_RST_WORD;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_rdata = s_reg.rdata;

	//=====================================================================
	// Link side
	// Slot timing, receive capture and transmit shifting
	always_comb begin
		logic tbit; // Transmit bit for this edge
		tbit           = 1'b0;
		l_next         = l_reg;
		l_next.rx_load = 1'b0;
		if (cfg_valid) begin
			l_next.cfg = cfg_in;
		end
		// Sync marks bit 0 of slot 0; the count free-runs after it
		if (i_link_fsync) begin
			l_next.active = 1'b1;
			l_next.slot   = '0;
			l_next.bitn   = '0;
		end else if (l_reg.active) begin
			if (l_reg.bitn == LAST) begin
				l_next.bitn = '0;
				l_next.slot = l_reg.slot + 1'b1;
			end else begin
				l_next.bitn = l_reg.bitn + 1'b1;
			end
		end
		// Enables indexed by the slot of this bit
		l_next.rx_on = l_reg.cfg.rx_en[l_next.slot];
		l_next.tx_on = l_reg.cfg.tx_en[l_next.slot];
		if (l_next.active) begin
			l_next.rxsh = {l_reg.rxsh[CSEC_DW-2:0], i_codec_serial_in};
			// Word taken at the slot's first bit, MSB first
			if (l_next.bitn == '0) begin
				tbit        = l_reg.cfg.txd[CSEC_DW-1];
				l_next.txsh = {l_reg.cfg.txd[CSEC_DW-2:0], 1'b0};
			end else begin
				tbit        = l_reg.txsh[CSEC_DW-1];
				l_next.txsh = {l_reg.txsh[CSEC_DW-2:0], 1'b0};
			end
			l_next.sdo = l_next.tx_on & tbit;
			l_next.oe  = l_next.tx_on | l_reg.cfg.mode;
			// Hand over only words of enabled slots; others are dropped
			if ((l_next.bitn == LAST) && l_next.rx_on && rxw_ready) begin
				l_next.rx_load      = 1'b1;
				l_next.rx_word.slot = l_next.slot;
				l_next.rx_word.data = l_next.rxsh;
			end
		end else begin
			// Position unknown until the first sync: stay off the wire
			l_next.sdo = 1'b0;
			l_next.oe  = 1'b0;
		end
	end

	// Link clock may stop between frames; nothing waits on it
	always_ff @(posedge i_link_clk) begin
		if (!lrst_n) begin
			l_reg <= '0;
		end else begin
			l_reg <= l_next;
		end
	end

	assign o_codec_serial_out    = l_reg.sdo;
	assign o_codec_serial_out_oe = l_reg.oe;

	//=====================================================================
	// Assertions
	rx_take_a: assert property (@(posedge i_link_clk) disable iff (!lrst_n)
		l_reg.rx_load |-> (l_reg.rx_on && (l_reg.bitn == LAST)
			&& (l_reg.rx_word.data[0] == $past(i_codec_serial_in))))
		else $error("receive word taken outside an enabled slot end");

	rx_drop_a: assert property (@(posedge i_link_clk) disable iff (!lrst_n)
		(l_reg.active && !l_reg.rx_on) |-> !l_reg.rx_load)
		else $error("word of a disabled receive slot handed over");

	tx_first_a: assert property (@(posedge i_link_clk) disable iff (!lrst_n)
		(l_reg.active && l_reg.tx_on && (l_reg.bitn == '0))
		|-> (o_codec_serial_out_oe && (o_codec_serial_out == $past(l_reg.cfg.txd[CSEC_DW-1]))))
		else $error("enabled slot does not start with the word MSB");

	idle_out_a: assert property (@(posedge i_link_clk) disable iff (!lrst_n)
		(l_reg.active && !l_reg.tx_on)
		|-> (!o_codec_serial_out && (o_codec_serial_out_oe == $past(l_reg.cfg.mode))))
		else $error("disabled slot output not idle per mode");

	en_reset_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		$rose(i_rstn) |-> ((s_reg.rx_en == CSEC_RST_WORD) && (s_reg.tx_en == CSEC_RST_WORD)))
		else $error("slot enables not cleared by reset");

	en_write_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(i_wr && at(i_addr, CSEC_OFS_RXEN)) |=> ##1 (i_rd && at(i_addr, CSEC_OFS_RXEN))
		|=> (o_rdata == $past(i_wdata, 3)) or $past(i_wr, 2))
		else $error("receive enables do not read back");

	slot_start_a: assert property (@(posedge i_link_clk) disable iff (!lrst_n)
		i_link_fsync |=> ((l_reg.slot == '0) && (l_reg.bitn == '0)))
		else $error("frame sync does not restart the slot count");

	slot_step_a: assert property (@(posedge i_link_clk) disable iff (!lrst_n)
		(l_reg.active && (l_reg.bitn == LAST) && !i_link_fsync)
		|=> (l_reg.slot == CSEC_SLOT_W'($past(l_reg.slot) + 1'b1)))
		else $error("slot count does not step at the slot end");

	rdata_idle_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		!i_rd |=> (o_rdata == '0))
		else $error("read data present without a read");

	word_seen_c: cover property (@(posedge i_mclk) disable iff (!i_rstn) $rose(s_reg.ready));
	tx_slot_c: cover property (@(posedge i_link_clk) disable iff (!lrst_n) l_reg.active && l_reg.tx_on);
	low_idle_c: cover property (@(posedge i_link_clk) disable iff (!lrst_n) l_reg.oe && !l_reg.tx_on);
	overrun_c: cover property (@(posedge i_mclk) disable iff (!i_rstn) $rose(s_reg.ovf));
endmodule
`default_nettype wire

// ### verification/csec_codec_model.sv
// Behavioural codec at the far end of the TDM link: makes clock, sync and input data, captures output
`timescale 1ns/100ps
`default_nettype none
module csec_codec_model #(
	parameter int SLOT_BITS = 12
) (
	// Link clock and frame sync made by the codec
	output logic      o_link_clk,
	output logic      o_fsync,
	// Serial data in both directions
	output logic      o_sdi,
	input  wire logic i_sdo,
	input  wire logic i_oe
);
	//=====================================================================
	// Frame geometry and capture store
	localparam int FRAME = 16 * SLOT_BITS; // Bits per frame
	logic [15:0] cap_sdo [16]; // Output bits seen per slot, first bit at bit 15
	logic [15:0] cap_oe  [16]; // Output enable seen per bit
	logic [15:0] word;         // Word being sent in the coming slot
	int          cur;          // Position begun at the last rising edge
	int          nxt;          // Position of the coming rising edge
	int          frames;       // Frames completed so far

	// Word this codec sends in slot s
	function automatic logic [15:0] pat(input int s);
		pat = 16'h39C0 + 16'(s);
	endfunction

	//=====================================================================
	// Bit clock runs free: the link logic needs it during reset too
	initial begin
		o_link_clk = 1'b0;
		o_fsync    = 1'b0;
		o_sdi      = 1'b0;
		cur        = FRAME - 1;
		nxt        = 0;
		frames     = 0;
		#7;
		forever #24 o_link_clk = ~o_link_clk;
	end

	// Position advances on the edge the device samples
	always @(posedge o_link_clk) begin
		cur <= nxt;
	end

	// Falling edge: record the settled output, then set up the next bit
	always @(negedge o_link_clk) begin
		cap_sdo[cur / SLOT_BITS][15 - cur % SLOT_BITS] = i_sdo;
		cap_oe[cur / SLOT_BITS][15 - cur % SLOT_BITS]  = i_oe;
		if (cur == FRAME - 1) begin
			frames = frames + 1;
		end
		nxt     = (cur + 1) % FRAME;
		word    = pat(nxt / SLOT_BITS);
		o_fsync = (nxt == 0);
		// Sent first bit first, so the slot word lands in the low bits
		o_sdi   = word[SLOT_BITS - 1 - nxt % SLOT_BITS];
	end
endmodule
`default_nettype wire

// ### verification/csec_top_bench.sv
// Self-checking testbench of the codec slot enable control block
`timescale 1ns/100ps
`default_nettype none
module csec_top_bench;
	import csec_pkg::*;
	//=====================================================================
	// Signals
	localparam int SB = 12;            // Short slots test the partial word path
	logic               i_mclk;        // System clock
	logic               i_rstn;        // Active low reset
	logic [CSEC_AW-1:0] i_addr;        // Register index
	logic [CSEC_DW-1:0] i_wdata;       // Write data
	logic               i_wr;          // Write strobe
	logic               i_rd;          // Read strobe
	logic [CSEC_DW-1:0] o_rdata;       // Read data
	logic               link_clk;      // Codec bit clock
	logic               fsync;         // Frame sync
	logic               sdi;           // Codec to device
	logic               sdo;           // Device to codec
	logic               sdo_oe;        // Device drives the output
	int                 num_errors;    // Mismatches
	int                 comparisons;   // Comparisons made

	//=====================================================================
	// Instances
	csec_top #(.SLOT_BITS(SB)) DUT (
		.i_mclk                (i_mclk),
		.i_rstn                (i_rstn),
		.i_addr                (i_addr),
		.i_wdata               (i_wdata),
		.i_wr                  (i_wr),
		.i_rd                  (i_rd),
		.o_rdata               (o_rdata),
		.i_link_clk            (link_clk),
		.i_link_fsync          (fsync),
		.i_codec_serial_in     (sdi),
		.o_codec_serial_out    (sdo),
		.o_codec_serial_out_oe (sdo_oe)
	);
	csec_codec_model #(.SLOT_BITS(SB)) model (
		.o_link_clk (link_clk),
		.o_fsync    (fsync),
		.o_sdi      (sdi),
		.i_sdo      (sdo),
		.i_oe       (sdo_oe)
	);

	// System clock, 25 MHz
	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end

	//=====================================================================
	// Shared tasks
	task automatic give_verdict;
		if (num_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// A bound ran out: count it and stop
	task automatic timed_out(input string what);
		num_errors++;
		$display("ERROR %0t: %s timed out", $time, what);
		give_verdict();
	endtask

	// One-cycle write strobe
	task automatic reg_wr(input logic [CSEC_AW-1:0] a, input logic [15:0] d);
		@(posedge i_mclk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr    <= 1'b0;
	endtask

	// One-cycle read strobe; data stand only in the following cycle
	task automatic reg_rd(input logic [CSEC_AW-1:0] a, output logic [15:0] d);
		@(posedge i_mclk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd   <= 1'b0;
		#1;
		d = o_rdata;
	endtask

	// Let n link frames end, the first possibly partial, bounded in system cycles
	task automatic wait_frames(input int n);
		int start;
		int k;
		start = model.frames;
		for (k = 0; k < n * 300 && model.frames < start + n; k++)
			@(posedge i_mclk);
		if (model.frames < start + n)
			timed_out("link frame");
	endtask

	//=====================================================================
	// Scenarios
	// Reset values, read back, unmapped places
	task automatic t_regs;
		logic [15:0] d;
		reg_rd(CSEC_OFS_RXEN, d);
		check(d, 16'h0000, "rx enables after reset");
		reg_rd(CSEC_OFS_TXEN, d);
		check(d, 16'h0000, "tx enables after reset");
		reg_rd(4'hF, d);
		check(d, 16'h0000, "unmapped read");
		// Read straight after the write, so the readback assertion is exercised
		reg_wr(CSEC_OFS_RXEN, 16'hA5C3);
		reg_rd(CSEC_OFS_RXEN, d);
		check(d, 16'hA5C3, "rx enables read back");
		reg_wr(CSEC_OFS_TXEN, 16'h5A3C);
		reg_wr(4'hF, 16'hFFFF);
		reg_rd(CSEC_OFS_TXEN, d);
		check(d, 16'h5A3C, "tx enables read back");
	endtask

	// Enabled slots carry the word, idle slots follow the mode
	task automatic t_tx(input logic mode, input logic [15:0] en);
		logic [15:0] txd;
		logic [15:0] m;
		logic [15:0] d;
		int          s;
		txd = 16'hA5F7;
		m   = 16'hFFFF << (16 - SB);
		reg_wr(CSEC_OFS_TXEN, en);
		reg_wr(CSEC_OFS_TXDATA, txd);
		reg_wr(CSEC_OFS_CTRL, {15'h0000, mode});
		reg_rd(CSEC_OFS_CTRL, d);
		check(d, {15'h0000, mode}, "control read back");
		// A frame may end just after the writes, before the new settings reach
		// the link, so the first counted frame is not judged
		wait_frames(3);
		for (s = 0; s < 16; s++) begin
			if (en[s]) begin
				check(model.cap_oe[s] & m, m, "tx slot enable");
				check(model.cap_sdo[s] & m, txd & m, "tx slot word");
			end else begin
				check(model.cap_oe[s] & m, mode ? m : 16'h0000, "idle slot enable");
				if (mode)
					check(model.cap_sdo[s] & m, 16'h0000, "idle slot level");
			end
		end
	endtask

	// Only enabled slots hand words over, in slot order
	task automatic t_rx;
		logic [15:0] d;
		logic [15:0] m;
		int          k;
		int          idx;
		int          slot;
		m = 16'hFFFF >> (16 - SB);
		reg_wr(CSEC_OFS_RXEN, 16'h0108);
		wait_frames(2);
		// Drain whatever arrived in the last frame
		reg_rd(CSEC_OFS_RXDATA, d);
		reg_rd(CSEC_OFS_STATUS, d);
		// Words kept arriving unread through the earlier scenarios
		check({15'h0000, d[CSEC_STAT_OVF_BIT]}, 16'h0001, "overrun after unread words");
		for (idx = 0; idx < 2; idx++) begin
			slot = (idx == 0) ? 3 : 8;
			d    = 16'h0000;
			for (k = 0; k < 200 && d[CSEC_STAT_RDY_BIT] !== 1'b1; k++)
				reg_rd(CSEC_OFS_STATUS, d);
			if (d[CSEC_STAT_RDY_BIT] !== 1'b1)
				timed_out("rx word");
			check({12'h000, d[CSEC_STAT_SLOT_LSB +: 4]}, 16'(slot), "rx slot index");
			check({15'h0000, d[CSEC_STAT_OVF_BIT]}, 16'h0000, "no overrun when read in time");
			reg_rd(CSEC_OFS_RXDATA, d);
			check(d & m, (16'h39C0 + 16'(slot)) & m, "rx slot word");
		end
	endtask

	//=====================================================================
	// Main sequence
	initial begin
		i_rstn      = 1'b0;
		i_addr      = '0;
		i_wdata     = '0;
		i_wr        = 1'b0;
		i_rd        = 1'b0;
		num_errors  = 0;
		comparisons = 0;
		repeat (6) @(posedge i_mclk);
		i_rstn <= 1'b1;
		t_regs();
		// Boundary slots 0 and 15 both ways, mode changed between runs
		t_tx(1'b1, 16'h8006);
		t_tx(1'b0, 16'h0181);
		t_rx();
		give_verdict();
	end
endmodule
`default_nettype wire
